// ===== verilog/backlight_params.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by its bare name wherever these constants are used.
// Notes:   Register offsets are byte-wide addresses on the register port.
// Functional notes
// - Mode 11 current comes from both serial brightness code and PWM duty.
// - Mode 11 ramps only between serial codes, never on duty changes.
// - Mode 11 multiplies ramp output by duty, so duty acts at once.
// - Boost control bit 5 picks 500 kHz or 1 MHz nominal frequency.
// - Boost control bit 6 lowers the switching frequency by twelve percent.
// - 250 kHz only exists in auto mode and halves maximum duty.
// - Auto mode compares both thresholds with the brightness high byte.
// - At/above high gives 1 MHz, between 500 kHz, below low 250 kHz.
// - Auto mode is on when either threshold is non-zero.
// - With auto mode off, bit 5 sets frequency at every current.
// - Slave address is 0x36 with select pin low, 0x37 when high.
// - Select pin is sampled once at power-up and must stay static.
// - Boost control bits 3:2 choose one of four overvoltage thresholds.
// - Overvoltage stops switching until output falls 1 V below threshold.
// - Overvoltage held over one millisecond sets fault bit 0.
// - Three overvoltage events with a low enabled sink set bits 0 and 4.
// - Overvoltage over 1 ms with a low enabled sink sets bits 0 and 4.
// - Register 0x1E bit 0 makes an overvoltage flag shut the device down.
// - After such shutdown, fault register must be read before re-enable.
// - Brightness code is 0x18 low three bits with 0x19, applied on 0x19.
`ifndef BACKLIGHT_PARAMS_SVH
`define BACKLIGHT_PARAMS_SVH
`define REG_BOOST_CONTROL   8'h13
`define REG_AUTO_FREQ_HIGH  8'h15
`define REG_AUTO_FREQ_LOW   8'h16
`define REG_BRIGHT_LOW      8'h18
`define REG_BRIGHT_HIGH     8'h19
`define REG_FAULT_CONTROL   8'h1e
`define REG_FAULT_FLAGS     8'h1f
`define BC_SHIFT_BIT        6
`define BC_FREQ_BIT         5
`define BC_MIN_IND_BIT      4
`define BC_OVP_MSB          3
`define BC_OVP_LSB          2
`define FF_OVP_BIT          0
`define FF_OPEN_BIT         4
`define FC_OVP_SD_BIT       0
`define BOOST_CONTROL_RST   8'h00
`define SLAVE_ADDR_LOW      7'h36
`define SLAVE_ADDR_HIGH     7'h37
`define OPEN_EVENT_LIMIT    2'h3
`define CLK_PERIOD_NS       20
`define OVP_FLAG_TIME_US    1000
`define OVP_FLAG_CYCLES     ((`OVP_FLAG_TIME_US * 1000) / `CLK_PERIOD_NS)
`define PERIOD_1M_NS        1000
`define PERIOD_1M_CYCLES    (`PERIOD_1M_NS / `CLK_PERIOD_NS)
`define SHIFT_PERCENT       12
`endif

// ===== verilog/backlight_pkg.sv
// Purpose: Types shared by the backlight boost control logic.
// Assumes: Nothing beyond the parameter header.
// Notes:   Frequency codes are one-hot so the period select is a plain mux.
package backlight_pkg;
  typedef enum logic [2:0] {
    FREQ_1M   = 3'b001,
    FREQ_500K = 3'b010,
    FREQ_250K = 3'b100
  } freq_t;
  typedef logic [10:0] code_t;
endpackage : backlight_pkg

// ===== verilog/backlight_boost_control.sv
// Purpose: Brightness path, boost frequency choice, address strap, faults.
// Assumes: Register port is the decoded output of the serial slave engine.
// Notes:   Analog comparators arrive as synchronous levels from the die.
`include "backlight_params.svh"
`timescale 1ns/100ps
`default_nettype none
module backlight_boost_control
  import backlight_pkg::*;
#(
  parameter int OVP_FLAG_CYCLES  = `OVP_FLAG_CYCLES,
  parameter int RAMP_STEP_CYCLES = 50000
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  input  wire logic        address_select_pin,
  input  wire logic        hardware_enable_pin,
  input  wire logic [1:0]  brightnessMode,
  input  wire logic [10:0] pwmDuty,
  input  wire logic        overvoltageAbove,
  input  wire logic        overvoltageBelowHyst,
  input  wire logic        sinkOneEnable,
  input  wire logic        sinkTwoEnable,
  input  wire logic        sink_one_voltage_low,
  input  wire logic        sink_two_voltage_low,
  output logic      [6:0]  slaveAddress,
  output logic      [1:0]  overvoltage_protection_sel,
  output logic             minInductorSel,
  output logic      [2:0]  switchFreq,
  output logic             periodTick,
  output logic             dutyLimitHalf,
  output logic             boostSwitchEn,
  output logic             deviceShutdown,
  output logic      [10:0] led_current
);

  localparam int P1M  = `PERIOD_1M_CYCLES;
  localparam int P500 = 2 * P1M;
  localparam int P250 = 4 * P1M;
  localparam int SHIFT_DIV = 100 - `SHIFT_PERCENT;

  // Elaboration-time guard on counts the counters cannot hold.
  // The period counter is eight bits, so the slowest stretched period must fit.
  generate
    if (OVP_FLAG_CYCLES < 1 || OVP_FLAG_CYCLES > 131071)
      $error("OVP_FLAG_CYCLES out of range");
    if (RAMP_STEP_CYCLES < 1 || RAMP_STEP_CYCLES > 65535)
      $error("RAMP_STEP_CYCLES out of range");
    if ((P250 * 100) / SHIFT_DIV > 255)
      $error("Clock too fast for the period counter");
  endgenerate

  typedef struct packed {
    logic [7:0]  boostCtl;
    logic [7:0]  thHigh;
    logic [7:0]  thLow;
    logic [2:0]  brtLow;
    logic [7:0]  brtHigh;
    logic [7:0]  faultCtl;
    code_t       brtCode;
    logic        ovpFlag;
    logic        openFlag;
    logic [16:0] ovpTimer;
    logic [1:0]  openEvents;
    logic        ovpPrev;
    logic        stopSwitch;
    logic        shutdown;
    logic        faultReadSeen;
    logic        enablePrev;
    code_t       rampCode;
    logic [15:0] rampTimer;
    logic [7:0]  periodCnt;
    freq_t       freq;
    logic        addrSel;
    logic        strapDone;
    logic [7:0]  rdData;
    code_t       ledCode;
  } state_t;

  state_t cur_q;
  state_t nxt_d;

  logic        autoMode;
  freq_t       wantFreq;
  logic [7:0]  periodLen;
  logic        anySinkLow;
  logic [21:0] product;
  code_t       rampTarget;
  code_t       dutyScaled;
  logic        faultRead;
  logic [21:0] ledProduct;

  // Frequency request: auto compare when either threshold is set.
  // High is tested first, so a zero high threshold in auto mode means 1 MHz.
  always_comb begin
    autoMode = (cur_q.thHigh != 8'h00) || (cur_q.thLow != 8'h00);
    if (autoMode) begin
      if (cur_q.brtHigh >= cur_q.thHigh) begin
        wantFreq = FREQ_1M;
      end else if (cur_q.brtHigh >= cur_q.thLow) begin
        wantFreq = FREQ_500K;
      end else begin
        wantFreq = FREQ_250K;
      end
    end else if (cur_q.boostCtl[`BC_FREQ_BIT]) begin
      wantFreq = FREQ_1M;
    end else begin
      wantFreq = FREQ_500K;
    end
  end

  // Period length for the frequency now running, stretched by the shift.
  // The shift is rounded down to whole clock cycles; a finer clock would be needed
  // for an exact twelve percent.
  always_comb begin
    case (cur_q.freq)
      FREQ_1M:   periodLen = 8'(P1M);
      FREQ_500K: periodLen = 8'(P500);
      FREQ_250K: periodLen = 8'(P250);
      default:   periodLen = 8'(P500);
    endcase
    if (cur_q.boostCtl[`BC_SHIFT_BIT]) begin
      periodLen = 8'((32'(periodLen) * 100) / SHIFT_DIV);
    end
  end

  // Brightness path: ramp target and output scaling depend on the mode.
  always_comb begin
    anySinkLow = (sinkOneEnable && sink_one_voltage_low) ||
                 (sinkTwoEnable && sink_two_voltage_low);
    faultRead  = regRdEn && (regAddr == `REG_FAULT_FLAGS);
    product    = 22'(cur_q.brtCode) * 22'(pwmDuty);
    dutyScaled = product[21:11];
    // Mode 11 scales after the ramper, so a duty change never waits a step.
    ledProduct = 22'(cur_q.rampCode) * 22'(pwmDuty);
    case (brightnessMode)
      2'b01:   rampTarget = pwmDuty;
      2'b10:   rampTarget = dutyScaled;
      default: rampTarget = cur_q.brtCode;
    endcase
  end

  // Next-state logic for every register of the block.
  always_comb begin
    nxt_d = cur_q;

    // Register writes; the brightness code moves only on the high byte.
    if (regWrEn) begin
      case (regAddr)
        `REG_BOOST_CONTROL:  nxt_d.boostCtl = regWrData;
        `REG_AUTO_FREQ_HIGH: nxt_d.thHigh   = regWrData;
        `REG_AUTO_FREQ_LOW:  nxt_d.thLow    = regWrData;
        `REG_BRIGHT_LOW:     nxt_d.brtLow   = regWrData[2:0];
        `REG_BRIGHT_HIGH: begin
          nxt_d.brtHigh = regWrData;
          nxt_d.brtCode = {regWrData, cur_q.brtLow};
        end
        `REG_FAULT_CONTROL:  nxt_d.faultCtl = regWrData;
        default:             nxt_d.faultCtl = cur_q.faultCtl;
      endcase
    end

    // Read data is registered; unmapped and reserved bits read zero.
    if (regRdEn) begin
      case (regAddr)
        `REG_BOOST_CONTROL:  nxt_d.rdData = cur_q.boostCtl;
        `REG_AUTO_FREQ_HIGH: nxt_d.rdData = cur_q.thHigh;
        `REG_AUTO_FREQ_LOW:  nxt_d.rdData = cur_q.thLow;
        `REG_BRIGHT_LOW:     nxt_d.rdData = {5'h00, cur_q.brtLow};
        `REG_BRIGHT_HIGH:    nxt_d.rdData = cur_q.brtHigh;
        `REG_FAULT_CONTROL:  nxt_d.rdData = cur_q.faultCtl;
        `REG_FAULT_FLAGS: begin
          nxt_d.rdData = 8'h00;
          nxt_d.rdData[`FF_OVP_BIT]  = cur_q.ovpFlag;
          nxt_d.rdData[`FF_OPEN_BIT] = cur_q.openFlag;
        end
        default:             nxt_d.rdData = 8'h00;
      endcase
    end

    // Address strap: caught once on the first edge after reset release.
    // Later moves of the pin are ignored, so the bus address never shifts.
    if (!cur_q.strapDone) begin
      nxt_d.addrSel   = address_select_pin;
      nxt_d.strapDone = 1'b1;
    end

    // Overvoltage gating with 1 V hysteresis held by the comparator pair.
    if (overvoltageAbove) begin
      nxt_d.stopSwitch = 1'b1;
    end else if (overvoltageBelowHyst) begin
      nxt_d.stopSwitch = 1'b0;
    end

    // Flags clear on a fault read; a new set in that cycle wins below.
    if (faultRead) begin
      nxt_d.ovpFlag    = 1'b0;
      nxt_d.openFlag   = 1'b0;
      nxt_d.openEvents = 2'h0;
    end

    // Continuous overvoltage timer; the flag needs strictly more than 1 ms.
    // Any dip below the limit restarts the count, so bursts never add up.
    nxt_d.ovpPrev = overvoltageAbove;
    if (!overvoltageAbove) begin
      nxt_d.ovpTimer = 17'h00000;
    end else if (32'(cur_q.ovpTimer) < OVP_FLAG_CYCLES) begin
      nxt_d.ovpTimer = cur_q.ovpTimer + 17'h00001;
    end else begin
      nxt_d.ovpFlag = 1'b1;
      if (anySinkLow) begin
        nxt_d.openFlag = 1'b1;
      end
    end

    // Count overvoltage onsets that coincide with a collapsed sink.
    // The count survives until a fault read, so slow repeats still trip it.
    if (overvoltageAbove && !cur_q.ovpPrev && anySinkLow) begin
      if (cur_q.openEvents == `OPEN_EVENT_LIMIT - 2'h1) begin
        nxt_d.ovpFlag  = 1'b1;
        nxt_d.openFlag = 1'b1;
      end else begin
        nxt_d.openEvents = nxt_d.openEvents + 2'h1;
      end
    end

    // Shutdown latches on a flag; release needs a read then a new enable.
    // Holding the flag, not the event, keeps the part down until it is read.
    nxt_d.enablePrev = hardware_enable_pin;
    if (cur_q.shutdown && faultRead) begin
      nxt_d.faultReadSeen = 1'b1;
    end
    if (cur_q.ovpFlag && cur_q.faultCtl[`FC_OVP_SD_BIT]) begin
      nxt_d.shutdown = 1'b1;
    end else if (cur_q.shutdown && cur_q.faultReadSeen &&
                 hardware_enable_pin && !cur_q.enablePrev) begin
      nxt_d.shutdown      = 1'b0;
      nxt_d.faultReadSeen = 1'b0;
    end

    // Ramp moves one code per step period toward the target.
    // Single steps bound the slope of the current whatever the code jump.
    if (cur_q.rampCode == rampTarget) begin
      nxt_d.rampTimer = 16'h0000;
    end else if (32'(cur_q.rampTimer) >= RAMP_STEP_CYCLES - 1) begin
      nxt_d.rampTimer = 16'h0000;
      if (cur_q.rampCode < rampTarget) begin
        nxt_d.rampCode = cur_q.rampCode + 11'h001;
      end else begin
        nxt_d.rampCode = cur_q.rampCode - 11'h001;
      end
    end else begin
      nxt_d.rampTimer = cur_q.rampTimer + 16'h0001;
    end

    // Mode 11 scales the ramp output by duty after the ramper.
    if (brightnessMode == 2'b11) begin
      nxt_d.ledCode = ledProduct[21:11];
    end else begin
      nxt_d.ledCode = cur_q.rampCode;
    end

    // Frequency changes land only on a switching-period boundary.
    if (cur_q.periodCnt >= periodLen - 8'h01) begin
      nxt_d.periodCnt = 8'h00;
      nxt_d.freq      = wantFreq;
    end else begin
      nxt_d.periodCnt = cur_q.periodCnt + 8'h01;
    end
  end

  // State register; constants only under reset. The enable history starts
  // at its idle level so that release never looks like a fresh enable edge.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cur_q          <= '0;
      cur_q.enablePrev <= 1'b1;
      cur_q.boostCtl <= `BOOST_CONTROL_RST;
      cur_q.freq     <= FREQ_500K;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Outputs; the shift is folded into the period tick, not the code.
  // Shutdown forces the current to zero here, after every other path.
  always_comb begin
    regRdData    = cur_q.rdData;
    slaveAddress = cur_q.addrSel ? `SLAVE_ADDR_HIGH
                                 : `SLAVE_ADDR_LOW;
    overvoltage_protection_sel =
      cur_q.boostCtl[`BC_OVP_MSB:`BC_OVP_LSB];
    minInductorSel = cur_q.boostCtl[`BC_MIN_IND_BIT];
    switchFreq     = cur_q.freq;
    periodTick     = (cur_q.periodCnt == 8'h00);
    dutyLimitHalf  = (cur_q.freq == FREQ_250K);
    boostSwitchEn  = !cur_q.stopSwitch && !cur_q.shutdown;
    deviceShutdown = cur_q.shutdown;
    led_current    = cur_q.shutdown ? 11'h000 : cur_q.ledCode;
  end

endmodule : backlight_boost_control
`default_nettype wire

// ===== testbench/backlight_boost_control_props.sv
// Purpose: Port-level properties of the backlight boost control block.
// Assumes: Bound to every instance of the block.
// Notes:   One clock domain, so clocking and reset are set once.
`timescale 1ns/100ps
`default_nettype none
module backlight_boost_control_props
  import backlight_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        regWrEn,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        address_select_pin,
  input wire logic        overvoltageAbove,
  input wire logic [6:0]  slaveAddress,
  input wire logic [1:0]  overvoltage_protection_sel,
  input wire logic        minInductorSel,
  input wire logic [2:0]  switchFreq,
  input wire logic        periodTick,
  input wire logic        dutyLimitHalf,
  input wire logic        boostSwitchEn,
  input wire logic        deviceShutdown,
  input wire logic [10:0] led_current
);
  // Every check uses the device clock and is quiet during reset.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Deep past terms keep the first edges after reset out of reach.
  a_strap_addr: assert property ($past(rst_b) && !$past(rst_b, 2) |->
    slaveAddress == ($past(address_select_pin) ? 7'h37 : 7'h36))
    else $error("slave address does not follow the strap");
  a_addr_static: assert property ($past(rst_b) && $past(rst_b, 2) |->
    $stable(slaveAddress))
    else $error("slave address moved after power-up");
  a_ovp_stop: assert property (overvoltageAbove |=> !boostSwitchEn)
    else $error("boost kept switching above the limit");
  a_ctrl_fields: assert property (regWrEn && regAddr == 8'h13 |=>
    overvoltage_protection_sel == $past(regWrData[3:2])
    && minInductorSel == $past(regWrData[4]))
    else $error("boost control fields not applied");
  a_freq_at_tick: assert property ($changed(switchFreq) |->
    periodTick || $past(periodTick))
    else $error("frequency changed inside a period");
  a_half_duty: assert property ($stable(switchFreq) |->
    dutyLimitHalf == (switchFreq == FREQ_250K))
    else $error("duty limit does not match low frequency");
  a_shut_gate: assert property (deviceShutdown && $past(deviceShutdown) |->
    !boostSwitchEn && led_current == 11'h000)
    else $error("output active during shutdown");
  a_period_gap: assert property (periodTick |=> !periodTick [*8])
    else $error("period ticks too close");
endmodule : backlight_boost_control_props
bind backlight_boost_control backlight_boost_control_props chk (
  .mclk(mclk), .rst_b(rst_b), .regWrEn(regWrEn), .regAddr(regAddr),
  .regWrData(regWrData), .address_select_pin(address_select_pin),
  .overvoltageAbove(overvoltageAbove), .slaveAddress(slaveAddress),
  .overvoltage_protection_sel(overvoltage_protection_sel),
  .minInductorSel(minInductorSel), .switchFreq(switchFreq),
  .periodTick(periodTick), .dutyLimitHalf(dutyLimitHalf),
  .boostSwitchEn(boostSwitchEn), .deviceShutdown(deviceShutdown),
  .led_current(led_current));
`default_nettype wire

// ===== testbench/reg_host_model.sv
// Purpose: Host model that writes and reads the block's registers.
// Assumes: Strobes rise and fall on falling clock edges, one cycle long.
// Notes:   Address and data are inverted after use so stale values mislead.
`timescale 1ns/100ps
`default_nettype none
module reg_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] regRdData,
  output var  logic       regWrEn,
  output var  logic       regRdEn,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData
);
  // The bus is idle from time zero.
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // Callers set bit 4 per inductor and keep low thresholds small.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge mclk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask : wr
  // Faults are read back before any re-enable is tried.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge mclk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask : rd
endmodule : reg_host_model
`default_nettype wire

// ===== testbench/test_backlight_boost_control.sv
// Purpose: Self-checking bench for the backlight boost control block.
// Assumes: Short fault and ramp counts keep the run under 10k cycles.
// Notes:   Inputs change only on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module test_backlight_boost_control
  import backlight_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_b, regWrEn, regRdEn, address_select_pin;
  logic        hardware_enable_pin, overvoltageAbove, overvoltageBelowHyst;
  logic        sinkOneEnable, sinkTwoEnable, sink_one_voltage_low;
  logic        sink_two_voltage_low, periodTick, dutyLimitHalf;
  logic        boostSwitchEn, deviceShutdown, minInductorSel;
  logic [7:0]  regAddr, regWrData, regRdData, rdVal;
  logic [1:0]  brightnessMode, overvoltage_protection_sel;
  logic [10:0] pwmDuty, led_current;
  logic [6:0]  slaveAddress;
  logic [2:0]  switchFreq;
  int          badCount = 0;
  int          nTests = 0;
  int          cycles = 0;

  backlight_boost_control #(.OVP_FLAG_CYCLES(20), .RAMP_STEP_CYCLES(2)) DUT (
    .mclk(mclk), .rst_b(rst_b), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .address_select_pin(address_select_pin),
    .hardware_enable_pin(hardware_enable_pin),
    .brightnessMode(brightnessMode), .pwmDuty(pwmDuty),
    .overvoltageAbove(overvoltageAbove),
    .overvoltageBelowHyst(overvoltageBelowHyst),
    .sinkOneEnable(sinkOneEnable), .sinkTwoEnable(sinkTwoEnable),
    .sink_one_voltage_low(sink_one_voltage_low),
    .sink_two_voltage_low(sink_two_voltage_low),
    .slaveAddress(slaveAddress),
    .overvoltage_protection_sel(overvoltage_protection_sel),
    .minInductorSel(minInductorSel), .switchFreq(switchFreq),
    .periodTick(periodTick), .dutyLimitHalf(dutyLimitHalf),
    .boostSwitchEn(boostSwitchEn), .deviceShutdown(deviceShutdown),
    .led_current(led_current));
  reg_host_model host (.mclk(mclk), .regRdData(regRdData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData));

  // Clock at 50 MHz and a ceiling that cuts a hang short.
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      badCount++;
      wrapUp();
    end
  end

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrapUp();
    $display("checks=%0d mismatches=%0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrapUp

  // Two tick intervals: the first lets a pending switch land.
  task automatic fq(input freq_t f, input int p);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (periodTick !== 1'b1) @(negedge mclk);
      do begin
        @(negedge mclk);
        n++;
      end while (periodTick !== 1'b1);
    end
    check(11'(switchFreq), 11'(f));
    check(11'(n), 11'(p));
    check(11'(dutyLimitHalf), 11'(f == FREQ_250K));
  endtask : fq

  // Overvoltage burst; the boost must stay off until below hysteresis.
  task automatic overvoltage_protection(input int n, input logic on);
    overvoltageAbove = 1'b1;
    overvoltageBelowHyst = 1'b0;
    repeat (n) @(negedge mclk);
    overvoltageAbove = 1'b0;
    repeat (2) @(negedge mclk);
    check(11'(boostSwitchEn), 11'h0);
    overvoltageBelowHyst = 1'b1;
    repeat (2) @(negedge mclk);
    check(11'(boostSwitchEn), 11'(on));
  endtask : overvoltage_protection

  task automatic testFixed();
    logic [7:0] v;
    host.rd(8'h13, rdVal);
    check(11'(rdVal), 11'h0);
    check(11'(slaveAddress), 11'h36);
    host.wr(8'h1f, 8'hff);
    host.rd(8'h1f, rdVal);
    check(11'(rdVal), 11'h0);
    host.rd(8'h20, rdVal);
    check(11'(rdVal), 11'h0);
    for (int i = 0; i < 4; i++) begin
      v = {1'b0, 2'(i), 1'b1, 2'(i), 2'b00};
      host.wr(8'h13, v);
      host.rd(8'h13, rdVal);
      check(11'(rdVal), 11'(v));
      check(11'(overvoltage_protection_sel), 11'(i));
      check(11'(minInductorSel), 11'h1);
      fq(v[5] ? FREQ_1M : FREQ_500K, v[5] ? (v[6] ? 56 : 50)
        : (v[6] ? 113 : 100));
    end
    $display("fixed frequency test done");
  endtask : testFixed

  task automatic testAuto();
    logic [7:0] b [4] = '{8'h80, 8'h7f, 8'h40, 8'h3f};
    freq_t      f [4] = '{FREQ_1M, FREQ_500K, FREQ_500K, FREQ_250K};
    int         p [4] = '{50, 100, 100, 200};
    host.wr(8'h13, 8'h10);
    host.wr(8'h15, 8'h80);
    host.wr(8'h16, 8'h40);
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h19, b[i]);
      fq(f[i], p[i]);
    end
    host.wr(8'h15, 8'h00);
    fq(FREQ_1M, 50);
    host.wr(8'h16, 8'h00);
    fq(FREQ_500K, 100);
    host.wr(8'h13, 8'h30);
    fq(FREQ_1M, 50);
    $display("auto frequency test done");
  endtask : testAuto

  task automatic testMode11();
    brightnessMode = 2'b11;
    pwmDuty = 11'd1024;
    host.wr(8'h18, 8'h07);
    host.wr(8'h19, 8'hff);
    repeat (5000) @(negedge mclk);
    check(led_current, 11'd1023);
    pwmDuty = 11'd2047;
    repeat (3) @(negedge mclk);
    check(led_current, 11'd2046);
    brightnessMode = 2'b01;
    pwmDuty = 11'd2044;
    repeat (20) @(negedge mclk);
    check(led_current, 11'd2044);
    brightnessMode = 2'b10;
    pwmDuty = 11'd2047;
    repeat (20) @(negedge mclk);
    check(led_current, 11'd2046);
    $display("mode 11 test done");
  endtask : testMode11

  task automatic testFaults();
    overvoltage_protection(30, 1'b1);
    host.rd(8'h1f, rdVal);
    check(11'(rdVal), 11'h01);
    host.rd(8'h1f, rdVal);
    check(11'(rdVal), 11'h00);
    sink_one_voltage_low = 1'b1;
    repeat (3) overvoltage_protection(4, 1'b1);
    host.rd(8'h1f, rdVal);
    check(11'(rdVal), 11'h11);
    overvoltage_protection(30, 1'b1);
    host.rd(8'h1f, rdVal);
    check(11'(rdVal), 11'h11);
    sink_one_voltage_low = 1'b0;
    host.wr(8'h1e, 8'h01);
    overvoltage_protection(30, 1'b0);
    check(11'(deviceShutdown), 11'h1);
    check(led_current, 11'h0);
    host.rd(8'h1f, rdVal);
    check(11'(rdVal), 11'h01);
    hardware_enable_pin = 1'b0;
    @(negedge mclk);
    hardware_enable_pin = 1'b1;
    repeat (3) @(negedge mclk);
    check(11'(deviceShutdown), 11'h0);
    $display("fault test done");
  endtask : testFaults

  task automatic testStrap();
    rst_b = 1'b0;
    address_select_pin = 1'b1;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    check(11'(slaveAddress), 11'h37);
    address_select_pin = 1'b0;
    repeat (3) @(negedge mclk);
    check(11'(slaveAddress), 11'h37);
    $display("strap test done");
  endtask : testStrap

  // Main sequence: reset for 16 cycles, then each test in turn.
  initial begin
    rst_b = 1'b0;
    address_select_pin = 1'b0;
    hardware_enable_pin = 1'b1;
    brightnessMode = 2'b00;
    pwmDuty = 11'h0;
    overvoltageAbove = 1'b0;
    overvoltageBelowHyst = 1'b1;
    sinkOneEnable = 1'b1;
    sinkTwoEnable = 1'b1;
    sink_one_voltage_low = 1'b0;
    sink_two_voltage_low = 1'b0;
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    testFixed();
    testAuto();
    testMode11();
    testFaults();
    testStrap();
    wrapUp();
  end
endmodule : test_backlight_boost_control
`default_nettype wire
